// [hdl/opdec_consts.svh]
// Constants for the first-quarter opcode decoder: opcode values,
// operand field positions, instruction lengths and cycle figures.
// Assumes inclusion by bare name from the two modules.
`ifndef OPDEC_CONSTS_SVH
`define OPDEC_CONSTS_SVH

// ----------------------------------------------------------------
// Opcode values and ranges
// ----------------------------------------------------------------
`define OPC_QUARTER_TOP   2'h0      // Opcode bits 7:6 of the decoded quarter
`define OPC_UNDEFINED     8'h3b     // Hole in the quarter, traps
`define OPC_MC_NOP        8'hcc     // Multicycle no-operation
`define OPC_MAC_LOW       8'h83     // Coprocessor instruction, first form
`define OPC_MAC_HIGH      8'ha3     // Coprocessor instruction, second form
`define OPC_DIV_LOW       4'hb      // Low nibble of every division opcode
`define OPC_DIV_HI_MIN    4'h4      // Division opcodes run 4B..7B
`define OPC_DIV_HI_MAX    4'h7

// ----------------------------------------------------------------
// Low-nibble groups of the quarter
// ----------------------------------------------------------------
`define LO_BITFIELD       4'ha
`define LO_MULPRIOR       4'hb
`define LO_ROTATE         4'hc
`define LO_JUMP           4'hd
`define LO_BIT_CLEAR      4'he
`define LO_BIT_SET        4'hf
`define LO_ARITH_MAX      4'h9

// ----------------------------------------------------------------
// Operand byte fields
// ----------------------------------------------------------------
`define OPD_FORM_MSB      3         // Bits 3:2 pick the indirect form
`define OPD_FORM_LSB      2
`define OPD_FORM_IMM3_A   2'h0      // x0..x3: three-bit immediate
`define OPD_FORM_IMM3_B   2'h1      // x4..x7: three-bit immediate
`define OPD_FORM_IND      2'h2      // x8..xB: register indirect
`define OPD_IMM3_MSB      2
`define OPD_PTR_MSB       1         // Only the four lowest registers point
`define OPD_DST_MSB       7
`define OPD_DST_LSB       4
`define OPD_NOP_MSB       4         // Low five bits count the stall

// ----------------------------------------------------------------
// Lengths in bytes and cycle figures
// ----------------------------------------------------------------
`define LEN_NONE          3'h0
`define LEN_SHORT         3'h2
`define LEN_LONG          3'h4
`define CYC_ZERO          5'h00
`define CYC_ONE           5'h01
`define CYC_TWO           5'h02
`define CYC_THREE         5'h03
`define CYC_FIVE          5'h05
`define CYC_SIX           5'h06
`define CYC_DIV_VISIBLE   5'h04
`define CYC_DIV_HIDDEN    5'h0f
`define CYC_NOP_MIN       5'h01

`endif

// [hdl/opdec_pkg.sv]
// Types shared by the decoder and its cycle resolver.
// Assumes the constants header sits in the include path.
package opdec_pkg;

  // Operation selected by the opcode
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_BITFIELD, OP_MUL, OP_UNSIGNED_MULTIPLY,
    OP_LEADING_ZERO_NORMALIZE, OP_ROL, OP_ROR, OP_JUMP, OP_BIT_CLEAR, OP_BIT_SET,
    OP_BIT_COMPARE, OP_BIT_MOVE_NEG, OP_DIV, OP_MC_NOP, OP_MAC,
    OP_TRAP, OP_FOREIGN
  } op_kind_t;

  // Operand form
  typedef enum logic [3:0] {
    FORM_RR, FORM_REG_MEM, FORM_MEM_REG, FORM_REG_IMM, FORM_IND_INC,
    FORM_IND, FORM_IMM3, FORM_BITFIELD, FORM_BITBIT, FORM_IMM4,
    FORM_REL, FORM_BITOFF, FORM_NONE
  } form_t;

  // Timing class
  typedef enum logic [3:0] {
    TIME_ONE, TIME_REG, TIME_BIT, TIME_BRANCH, TIME_SEG_2_3,
    TIME_SEG_5_6, TIME_DIV, TIME_MC_NOP, TIME_MAC, TIME_NONE
  } timing_t;

  // Relative jump condition (zero and nonzero are aliases)
  typedef enum logic [1:0] {
    COND_ALWAYS, COND_NOT_EQUAL_NOT_END, COND_EQUAL, COND_NOT_EQUAL
  } cond_t;

endpackage : opdec_pkg

// [hdl/cycle_resolver.sv]
// Turns a timing class plus run-time facts into a cycle count and
// keeps the background count that runs behind every division.
// Assumes all inputs come from logic on the same clock.
`include "opdec_consts.svh"

module cycle_resolver (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Decoded request
  input  wire logic              start,
  input  opdec_pkg::timing_t     timing,
  input  wire logic [4:0]        nop_count,
  // Run-time facts
  input  wire logic              reg_is_general,
  input  wire logic              bit_is_general,
  input  wire logic              zero_cycle_branch,
  input  wire logic              segmentation_disable,
  input  wire logic              mac_long,
  // Results
  output logic [4:0]             cycles,
  output logic                   result_pending
);

  logic [4:0] hidden_reg;   // Background division cycles left
  logic [4:0] hidden_next;
  logic [4:0] nop_cycles;   // Stall with the floor applied
  logic [4:0] visible_cycles;

  assign nop_cycles = (nop_count < `CYC_NOP_MIN) ? `CYC_NOP_MIN : nop_count;

  // Visible cycles per timing class
  always_comb
  begin
    case (timing)
      opdec_pkg::TIME_REG:     visible_cycles = reg_is_general ? `CYC_ONE : `CYC_TWO;
      opdec_pkg::TIME_BIT:     visible_cycles = bit_is_general ? `CYC_ONE : `CYC_TWO;
      opdec_pkg::TIME_BRANCH:  visible_cycles = zero_cycle_branch ? `CYC_ZERO : `CYC_ONE;
      opdec_pkg::TIME_SEG_2_3: visible_cycles = segmentation_disable ? `CYC_TWO : `CYC_THREE;
      opdec_pkg::TIME_SEG_5_6: visible_cycles = segmentation_disable ? `CYC_FIVE : `CYC_SIX;
      opdec_pkg::TIME_DIV:     visible_cycles = `CYC_DIV_VISIBLE;
      opdec_pkg::TIME_MC_NOP:  visible_cycles = nop_cycles;
      opdec_pkg::TIME_MAC:     visible_cycles = mac_long ? `CYC_TWO : `CYC_ONE;
      opdec_pkg::TIME_NONE:    visible_cycles = `CYC_ZERO;
      default:                 visible_cycles = `CYC_ONE;
    endcase
  end

  assign cycles = visible_cycles;

  assign hidden_next = (start && timing == opdec_pkg::TIME_DIV)
                     ? (`CYC_DIV_VISIBLE + `CYC_DIV_HIDDEN)
                     : (hidden_reg != `CYC_ZERO) ? hidden_reg - `CYC_ONE : `CYC_ZERO;

  // Background counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hidden_reg     <= `CYC_ZERO;
      result_pending <= 1'b0;
    end
    else
    begin
      hidden_reg     <= hidden_next;
      result_pending <= (hidden_next != `CYC_ZERO);
    end
  end

endmodule : cycle_resolver

// [hdl/opcode_decode_first_quarter.sv]
// Decoder for the one-byte opcodes 00..3F of the 16-bit core, plus
// the few timing forms (division, multicycle stall, coprocessor) that
// the cycle classes of this quarter share with the rest of the map.
// Assumes the fetch unit presents an opcode with its operand byte and
// the run-time facts in the same cycle, all on CLK_SYS.
`include "opdec_consts.svh"

// What this block does
// - register class, one or two cycles
// - bit class, one or two cycles
// - relative jump, zero or one cycle
// - two-three class in the resolver, never selected by a decode here
// - five-six class in the resolver, never selected by a decode here
// - division, four visible plus fifteen hidden
// - multicycle stall from five operand bits
// - word ops 08..38 decode three forms
// - byte ops 09..39 same three forms
// - jump condition comes from the opcode
// - 0A/1A masked field update, low/high
// - bit position taken from the opcode
// - undefined opcode raises a trap
module opcode_decode_first_quarter (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // Fetch side
  input  wire logic        OPC_VALID,
  input  wire logic [7:0]  OPC_BYTE,
  input  wire logic [7:0]  OPD_BYTE,
  // Run-time facts
  input  wire logic        REG_IS_GENERAL,
  input  wire logic        BIT_IS_GENERAL,
  input  wire logic        ZERO_CYCLE_BRANCH,
  input  wire logic        SEGMENTATION_DISABLE,
  input  wire logic        MAC_LONG,
  // Decoded controls
  output logic             DEC_VALID,
  output logic [4:0]       DEC_OP,
  output logic             DEC_WORD,
  output logic [3:0]       DEC_FORM,
  output logic [3:0]       DEC_TIMING,
  output logic [2:0]       DEC_LENGTH,
  output logic [4:0]       DEC_CYCLES,
  output logic [1:0]       DEC_COND,
  output logic [3:0]       DEC_BIT_POS,
  output logic             DEC_FIELD_HIGH,
  output logic [3:0]       DEC_DST_REG,
  output logic [1:0]       DEC_PTR_REG,
  output logic [2:0]       DEC_IMM3,
  output logic             DEC_TRAP,
  output logic             DEC_FOREIGN,
  // Division status
  output logic             RESULT_PENDING
);

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  logic [3:0] lo_nib;         // Opcode low nibble
  logic [3:0] hi_nib;         // Opcode high nibble
  logic [1:0] row;            // Bits 5:4, row within the quarter
  logic       in_quarter;     // Opcode lies in 00..3F
  logic       is_arith;       // Low nibble 0..9
  logic       is_div;         // 4B, 5B, 6B, 7B
  logic       is_mc_nop;      // Multicycle stall
  logic       is_mac;         // Coprocessor forms
  logic       is_undefined;   // Hole in the quarter
  logic [1:0] ind_sel;        // Operand byte bits 3:2

  assign lo_nib       = OPC_BYTE[3:0];
  assign hi_nib       = OPC_BYTE[7:4];
  assign row          = OPC_BYTE[5:4];
  assign in_quarter   = (OPC_BYTE[7:6] == `OPC_QUARTER_TOP);
  assign is_arith     = in_quarter && (lo_nib <= `LO_ARITH_MAX);
  assign is_div       = (lo_nib == `OPC_DIV_LOW) && (hi_nib >= `OPC_DIV_HI_MIN)
                     && (hi_nib <= `OPC_DIV_HI_MAX);
  assign is_mc_nop    = (OPC_BYTE == `OPC_MC_NOP);
  assign is_mac       = (OPC_BYTE == `OPC_MAC_LOW) || (OPC_BYTE == `OPC_MAC_HIGH);
  assign is_undefined = (OPC_BYTE == `OPC_UNDEFINED);
  assign ind_sel      = OPD_BYTE[`OPD_FORM_MSB:`OPD_FORM_LSB];

  // ----------------------------------------------------------------
  // Arithmetic group operation and operand form
  // ----------------------------------------------------------------
  opdec_pkg::op_kind_t arith_op;    // Add, add-carry, subtract, borrow
  opdec_pkg::form_t    arith_form;  // Form from low nibble and operand
  opdec_pkg::form_t    ind_form;    // Short indirect forms

  assign arith_op = (row == 2'h0) ? opdec_pkg::OP_ADD
                  : (row == 2'h1) ? opdec_pkg::OP_ADD_WITH_CARRY
                  : (row == 2'h2) ? opdec_pkg::OP_SUB
                  :                 opdec_pkg::OP_SUBTRACT_WITH_BORROW;

  assign ind_form = (ind_sel == `OPD_FORM_IMM3_A || ind_sel == `OPD_FORM_IMM3_B)
                  ? opdec_pkg::FORM_IMM3
                  : (ind_sel == `OPD_FORM_IND) ? opdec_pkg::FORM_IND
                  : opdec_pkg::FORM_IND_INC;

  assign arith_form = (lo_nib[3:1] == 3'h0) ? opdec_pkg::FORM_RR
                    : (lo_nib[3:1] == 3'h1) ? opdec_pkg::FORM_REG_MEM
                    : (lo_nib[3:1] == 3'h2) ? opdec_pkg::FORM_MEM_REG
                    : (lo_nib[3:1] == 3'h3) ? opdec_pkg::FORM_REG_IMM
                    :                         ind_form;

  // ----------------------------------------------------------------
  // Full decode table
  // ----------------------------------------------------------------
  opdec_pkg::op_kind_t op_next;
  opdec_pkg::form_t    form_next;
  opdec_pkg::timing_t  timing_next;
  logic [2:0]          length_next;
  logic                word_next;

  // Operation, form, timing class and length for each opcode
  always_comb
  begin
    op_next     = opdec_pkg::OP_FOREIGN;
    form_next   = opdec_pkg::FORM_NONE;
    timing_next = opdec_pkg::TIME_NONE;
    length_next = `LEN_NONE;
    word_next   = ~OPC_BYTE[0];
    if (is_undefined)
    begin
      op_next = opdec_pkg::OP_TRAP;
    end
    else if (is_arith)
    begin
      op_next     = arith_op;
      form_next   = arith_form;
      length_next = (lo_nib[3:1] == 3'h0 || lo_nib[3:1] == 3'h4) ? `LEN_SHORT : `LEN_LONG;
      timing_next = (lo_nib[3:1] == 3'h1 || lo_nib[3:1] == 3'h2)
                  ? opdec_pkg::TIME_REG : opdec_pkg::TIME_ONE;
    end
    else if (in_quarter)
    begin
      case (lo_nib)
        `LO_BITFIELD:
        begin
          length_next = `LEN_LONG;
          if (!row[1])
          begin
            op_next     = opdec_pkg::OP_BITFIELD;
            form_next   = opdec_pkg::FORM_BITFIELD;
            timing_next = opdec_pkg::TIME_ONE;
          end
          else
          begin
            // Bit compare or negated bit move
            op_next     = row[0] ? opdec_pkg::OP_BIT_MOVE_NEG : opdec_pkg::OP_BIT_COMPARE;
            form_next   = opdec_pkg::FORM_BITBIT;
            timing_next = opdec_pkg::TIME_BIT;
          end
        end
        `LO_MULPRIOR:
        begin
          // Multiply signed, unsigned, normalise
          op_next     = (row == 2'h0) ? opdec_pkg::OP_MUL
                      : (row == 2'h1) ? opdec_pkg::OP_UNSIGNED_MULTIPLY : opdec_pkg::OP_LEADING_ZERO_NORMALIZE;
          form_next   = opdec_pkg::FORM_RR;
          timing_next = opdec_pkg::TIME_ONE;
          length_next = `LEN_SHORT;
          word_next   = 1'b1;
        end
        `LO_ROTATE:
        begin
          // Rotate by register or by four-bit count
          op_next     = row[1] ? opdec_pkg::OP_ROR : opdec_pkg::OP_ROL;
          form_next   = row[0] ? opdec_pkg::FORM_IMM4 : opdec_pkg::FORM_RR;
          timing_next = opdec_pkg::TIME_ONE;
          length_next = `LEN_SHORT;
          word_next   = 1'b1;
        end
        `LO_JUMP:
        begin
          op_next     = opdec_pkg::OP_JUMP;
          form_next   = opdec_pkg::FORM_REL;
          timing_next = opdec_pkg::TIME_BRANCH;
          length_next = `LEN_SHORT;
          word_next   = 1'b1;
        end
        default:
        begin
          // Bit clear and bit set, two bytes, one cycle
          op_next     = (lo_nib == `LO_BIT_SET) ? opdec_pkg::OP_BIT_SET : opdec_pkg::OP_BIT_CLEAR;
          form_next   = opdec_pkg::FORM_BITOFF;
          timing_next = opdec_pkg::TIME_ONE;
          length_next = `LEN_SHORT;
          word_next   = 1'b1;
        end
      endcase
    end
    else if (is_div)
    begin
      op_next     = opdec_pkg::OP_DIV;
      form_next   = opdec_pkg::FORM_RR;
      timing_next = opdec_pkg::TIME_DIV;
      length_next = `LEN_SHORT;
    end
    else if (is_mc_nop)
    begin
      op_next     = opdec_pkg::OP_MC_NOP;
      timing_next = opdec_pkg::TIME_MC_NOP;
      length_next = `LEN_SHORT;
    end
    else if (is_mac)
    begin
      op_next     = opdec_pkg::OP_MAC;
      timing_next = opdec_pkg::TIME_MAC;
      length_next = `LEN_LONG;
    end
  end

  // ----------------------------------------------------------------
  // Side fields
  // ----------------------------------------------------------------
  opdec_pkg::cond_t cond_next;    // Jump condition
  logic [3:0]       bit_pos_next; // Target bit of clear or set

  assign cond_next = (row == 2'h0) ? opdec_pkg::COND_ALWAYS
                   : (row == 2'h1) ? opdec_pkg::COND_NOT_EQUAL_NOT_END
                   : (row == 2'h2) ? opdec_pkg::COND_EQUAL
                   :                 opdec_pkg::COND_NOT_EQUAL;

  assign bit_pos_next = hi_nib;

  // ----------------------------------------------------------------
  // Cycle count
  // ----------------------------------------------------------------
  logic [4:0] cycles_now;   // Cycles for the opcode now offered
  logic       pending_now;  // Quotient not yet available

  cycle_resolver u_cycles (
    .clk                  (CLK_SYS),
    .rst                  (RST),
    .start                (OPC_VALID),
    .timing               (timing_next),
    .nop_count            (OPD_BYTE[`OPD_NOP_MSB:0]),
    .reg_is_general       (REG_IS_GENERAL),
    .bit_is_general       (BIT_IS_GENERAL),
    .zero_cycle_branch    (ZERO_CYCLE_BRANCH),
    .segmentation_disable (SEGMENTATION_DISABLE),
    .mac_long             (MAC_LONG),
    .cycles               (cycles_now),
    .result_pending       (pending_now)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Capture one decode per valid opcode
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      DEC_VALID      <= 1'b0;
      DEC_OP         <= 5'h00;
      DEC_WORD       <= 1'b0;
      DEC_FORM       <= 4'h0;
      DEC_TIMING     <= 4'h0;
      DEC_LENGTH     <= `LEN_NONE;
      DEC_CYCLES     <= `CYC_ZERO;
      DEC_COND       <= 2'h0;
      DEC_BIT_POS    <= 4'h0;
      DEC_FIELD_HIGH <= 1'b0;
      DEC_DST_REG    <= 4'h0;
      DEC_PTR_REG    <= 2'h0;
      DEC_IMM3       <= 3'h0;
      DEC_TRAP       <= 1'b0;
      DEC_FOREIGN    <= 1'b0;
    end
    else
    begin
      DEC_VALID <= OPC_VALID;
      if (OPC_VALID)
      begin
        DEC_OP         <= op_next;
        DEC_WORD       <= word_next;
        DEC_FORM       <= form_next;
        DEC_TIMING     <= timing_next;
        DEC_LENGTH     <= length_next;
        DEC_CYCLES     <= cycles_now;
        DEC_COND       <= cond_next;
        DEC_BIT_POS    <= bit_pos_next;
        DEC_FIELD_HIGH <= row[0];
        DEC_DST_REG    <= OPD_BYTE[`OPD_DST_MSB:`OPD_DST_LSB];
        DEC_PTR_REG    <= OPD_BYTE[`OPD_PTR_MSB:0];
        DEC_IMM3       <= OPD_BYTE[`OPD_IMM3_MSB:0];
        DEC_TRAP       <= is_undefined;
        DEC_FOREIGN    <= (op_next == opdec_pkg::OP_FOREIGN);
      end
    end
  end

  // Division status comes straight from the resolver's flop
  assign RESULT_PENDING = pending_now;

endmodule : opcode_decode_first_quarter

// [testbench/opdec_monitor.sv]
// Checker for the first-quarter opcode decoder, bound to its top.
// Assumes it sees only the decoder's ports, all on CLK_SYS.
module opdec_monitor (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // Fetch side and facts
  input wire logic       OPC_VALID,
  input wire logic [7:0] OPC_BYTE,
  input wire logic [7:0] OPD_BYTE,
  input wire logic       REG_IS_GENERAL,
  input wire logic       ZERO_CYCLE_BRANCH,
  input wire logic       MAC_LONG,
  // Decoded controls
  input wire logic       DEC_VALID,
  input wire logic [2:0] DEC_LENGTH,
  input wire logic [4:0] DEC_CYCLES,
  input wire logic [1:0] DEC_COND,
  input wire logic [3:0] DEC_BIT_POS,
  input wire logic       DEC_TRAP,
  input wire logic       RESULT_PENDING
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Opcode fields
  wire logic       q     = OPC_VALID && OPC_BYTE[7:6] == 2'h0;
  wire logic [3:0] lo    = OPC_BYTE[3:0];
  wire logic [3:0] hi    = OPC_BYTE[7:4];
  wire logic [1:0] row   = OPC_BYTE[5:4];
  wire logic [4:0] stall = OPD_BYTE[4:0];
  wire logic       div   = OPC_VALID && OPC_BYTE[7:6] == 2'h1 && lo == 4'hb;
  logic      [4:0] left_reg;  // Cycles of quotient wait still due
  // ------------------------------------------------------------
  // Division shadow count
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      left_reg <= 5'h00;
    else if (div)
      left_reg <= 5'h13;
    else if (left_reg != 5'h00)
      left_reg <= left_reg - 5'h01;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_answer; DEC_VALID == $past(OPC_VALID); endproperty
  property p_reg; q && lo inside {[4'h2:4'h5]} |=> DEC_LENGTH == 3'h4 && DEC_CYCLES == 5'h02 - $past(REG_IS_GENERAL);
  endproperty
  property p_jump; q && lo == 4'hd |=> DEC_CYCLES == {4'h0, !$past(ZERO_CYCLE_BRANCH)} && DEC_COND == $past(row);
  endproperty
  property p_div; RESULT_PENDING == (left_reg != 5'h00); endproperty
  property p_nop; OPC_VALID && OPC_BYTE == 8'hcc |=> DEC_CYCLES == (($past(stall) == 5'h00) ? 5'h01 : $past(stall));
  endproperty
  property p_mac; OPC_VALID && (OPC_BYTE == 8'h83 || OPC_BYTE == 8'ha3) |=> DEC_CYCLES == 5'h01 + $past(MAC_LONG);
  endproperty
  property p_trap; OPC_VALID && OPC_BYTE == 8'h3b |=> DEC_TRAP && DEC_LENGTH == 3'h0 && DEC_CYCLES == 5'h00;
  endproperty
  property p_bitpos; q && lo >= 4'he |=> DEC_BIT_POS == $past(hi); endproperty
  a_answer: assert property (p_answer) else $error("decode pulse misplaced");
  a_reg: assert property (p_reg) else $error("register class wrong");
  a_jump: assert property (p_jump) else $error("jump cycles or condition wrong");
  a_div: assert property (p_div) else $error("quotient wait wrong");
  a_nop: assert property (p_nop) else $error("stall count wrong");
  a_mac: assert property (p_mac) else $error("coprocessor cycles wrong");
  a_trap: assert property (p_trap) else $error("hole not trapped");
  a_bitpos: assert property (p_bitpos) else $error("bit position wrong");
  c_div: cover property (div ##1 RESULT_PENDING);
  c_trap: cover property (DEC_TRAP);
  c_stall: cover property (OPC_VALID && OPC_BYTE == 8'hcc);
endmodule : opdec_monitor

bind opcode_decode_first_quarter opdec_monitor i_opdec_monitor (.*);

// [testbench/exec_sink.sv]
// Execution pipeline stand-in: accepts every decoded pulse.
// Assumes the decoder's pulse and the core clock and reset.
module exec_sink (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Decoded pulse
  input  wire logic dec_valid,
  // Decodes taken so far
  output int        taken
);
  // One decode taken per pulse; reset empties the count
  always_ff @(posedge clk)
  begin
    if (rst)
      taken <= 0;
    else if (dec_valid)
      taken <= taken + 1;
  end
endmodule : exec_sink

// [testbench/opcode_decode_first_quarter_tb.sv]
// Self-checking bench for the first-quarter opcode decoder.
// Assumes the package, header and design compile first.
module opcode_decode_first_quarter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus
  logic       CLK_SYS = 1'b0;
  logic       RST = 1'b1;
  logic       OPC_VALID = 1'b0;
  logic [7:0] OPC_BYTE = 8'h00;
  logic [7:0] OPD_BYTE = 8'h00;
  logic       REG_IS_GENERAL = 1'b0, BIT_IS_GENERAL = 1'b0, ZERO_CYCLE_BRANCH = 1'b0;
  logic       SEGMENTATION_DISABLE = 1'b0, MAC_LONG = 1'b0;
  // Design outputs
  logic       DEC_VALID, DEC_WORD, DEC_FIELD_HIGH, DEC_TRAP, DEC_FOREIGN, RESULT_PENDING;
  logic [4:0] DEC_OP, DEC_CYCLES;
  logic [3:0] DEC_FORM, DEC_TIMING, DEC_BIT_POS, DEC_DST_REG;
  logic [2:0] DEC_LENGTH, DEC_IMM3;
  logic [1:0] DEC_COND, DEC_PTR_REG;
  // Expectations and the previous request
  logic [4:0] e_op, e_cyc, p_f;
  logic [3:0] e_form, e_tim;
  logic [2:0] e_len;
  logic [7:0] p_o, p_d;
  logic       e_word, full, fr, p_v = 1'b0;
  int         num_errors = 0, total_checks = 0, pend = 0, n_req = 0, taken;
  logic [7:0] corner [10] = '{8'h3b, 8'h4b, 8'h6b, 8'hcc, 8'h83, 8'ha3, 8'h40, 8'hff, 8'h0d, 8'h3a};

  always #12.5 CLK_SYS = ~CLK_SYS;

  opcode_decode_first_quarter i_opcode_decode_first_quarter (.*);
  exec_sink i_exec_sink (.clk(CLK_SYS), .rst(RST), .dec_valid(DEC_VALID), .taken(taken));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Expected decode of one opcode, operand byte and facts
  function automatic void calc(input logic [7:0] o, input logic [7:0] d, input logic [4:0] f);
    logic [3:0] lo;
    logic [1:0] row;
    lo = o[3:0];
    row = o[5:4];
    full = (o[7:6] == 2'h0) && (o != 8'h3b);
    fr = 1'b0;
    e_word = (lo <= 4'h9) ? !o[0] : 1'b1;
    e_len = (lo inside {[4'h2:4'h7], 4'ha}) ? 3'h4 : 3'h2;
    e_tim = (lo inside {[4'h2:4'h5]}) ? opdec_pkg::TIME_REG : (lo == 4'ha && row[1]) ? opdec_pkg::TIME_BIT
          : (lo == 4'hd) ? opdec_pkg::TIME_BRANCH : opdec_pkg::TIME_ONE;
    e_cyc = (lo inside {[4'h2:4'h5]}) ? 5'h02 - 5'(f[0]) : (e_tim == opdec_pkg::TIME_BIT) ? 5'h02 - 5'(f[1])
          : (lo == 4'hd) ? 5'(!f[2]) : 5'h01;
    case (lo)
      4'h2, 4'h3: e_form = opdec_pkg::FORM_REG_MEM;
      4'h4, 4'h5: e_form = opdec_pkg::FORM_MEM_REG;
      4'h6, 4'h7: e_form = opdec_pkg::FORM_REG_IMM;
      4'h8, 4'h9: e_form = d[3] ? (d[2] ? opdec_pkg::FORM_IND_INC : opdec_pkg::FORM_IND) : opdec_pkg::FORM_IMM3;
      4'ha: e_form = row[1] ? opdec_pkg::FORM_BITBIT : opdec_pkg::FORM_BITFIELD;
      4'hc: e_form = row[0] ? opdec_pkg::FORM_IMM4 : opdec_pkg::FORM_RR;
      4'hd: e_form = opdec_pkg::FORM_REL;
      4'he, 4'hf: e_form = opdec_pkg::FORM_BITOFF;
      default: e_form = opdec_pkg::FORM_RR;
    endcase
    case (lo)
      4'ha: e_op = row[1] ? (row[0] ? opdec_pkg::OP_BIT_MOVE_NEG : opdec_pkg::OP_BIT_COMPARE) : opdec_pkg::OP_BITFIELD;
      4'hb: e_op = row[1] ? opdec_pkg::OP_LEADING_ZERO_NORMALIZE : (row[0] ? opdec_pkg::OP_UNSIGNED_MULTIPLY : opdec_pkg::OP_MUL);
      4'hc: e_op = row[1] ? opdec_pkg::OP_ROR : opdec_pkg::OP_ROL;
      4'hd: e_op = opdec_pkg::OP_JUMP;
      4'he: e_op = opdec_pkg::OP_BIT_CLEAR;
      4'hf: e_op = opdec_pkg::OP_BIT_SET;
      default: e_op = {3'h0, row};
    endcase
    // The hole traps; the upper forms are division, stall, coprocessor or foreign
    if (o == 8'h3b)
    begin
      e_op = opdec_pkg::OP_TRAP;
      e_tim = opdec_pkg::TIME_NONE;
      e_len = 3'h0;
      e_cyc = 5'h00;
    end
    else if (!full)
    begin
      e_op = opdec_pkg::OP_MAC;
      e_tim = opdec_pkg::TIME_MAC;
      e_len = 3'h4;
      e_cyc = 5'(f[3]) + 5'h01;
      if (lo == 4'hb && o[7:6] == 2'h1)
      begin
        e_op = opdec_pkg::OP_DIV;
        e_tim = opdec_pkg::TIME_DIV;
        e_len = 3'h2;
        e_cyc = 5'h04;
      end
      else if (o == 8'hcc)
      begin
        e_op = opdec_pkg::OP_MC_NOP;
        e_tim = opdec_pkg::TIME_MC_NOP;
        e_len = 3'h2;
        e_cyc = (d[4:0] == 5'h00) ? 5'h01 : d[4:0];
      end
      else if (o != 8'h83 && o != 8'ha3)
      begin
        e_op = opdec_pkg::OP_FOREIGN;
        e_len = 3'h0;
        fr = 1'b1;
      end
    end
  endfunction : calc

  // Offer one request, then judge the one offered an edge earlier
  task automatic step(input logic v, input logic [7:0] o, input logic [7:0] d);
    @(posedge CLK_SYS);
    OPC_VALID <= v;
    OPC_BYTE <= o;
    OPD_BYTE <= d;
    {SEGMENTATION_DISABLE, MAC_LONG, ZERO_CYCLE_BRANCH, BIT_IS_GENERAL, REG_IS_GENERAL} <= 5'($urandom);
    #1;
    if (p_v)
    begin
      calc(p_o, p_d, p_f);
      chk("op", 16'(e_op), 16'(DEC_OP));
      chk("foreign", 16'(fr), 16'(DEC_FOREIGN));
      chk("trap", 16'(p_o == 8'h3b), 16'(DEC_TRAP));
      chk("length", 16'(e_len), 16'(DEC_LENGTH));
      if (!fr)
        chk("cycles", 16'(e_cyc), 16'(DEC_CYCLES));
      if (!fr)
        chk("timing", 16'(e_tim), 16'(DEC_TIMING));
      if (full)
      begin
        chk("word", 16'(e_word), 16'(DEC_WORD));
        chk("form", 16'(e_form), 16'(DEC_FORM));
        chk("cond bitpos high", 16'({p_o[5:4], p_o[7:4], p_o[4]}), 16'({DEC_COND, DEC_BIT_POS, DEC_FIELD_HIGH}));
        chk("operand", 16'({p_d[7:4], p_d[1:0], p_d[2:0]}), 16'({DEC_DST_REG, DEC_PTR_REG, DEC_IMM3}));
      end
    end
    chk("valid", 16'(p_v), 16'(DEC_VALID));
    if (p_v && p_o[7:6] == 2'h1 && p_o[3:0] == 4'hb)
      pend = 19;
    else if (pend > 0)
      pend--;
    chk("pending", 16'(pend > 0), 16'(RESULT_PENDING));
    p_v = v;
    p_o = o;
    p_d = d;
    p_f = {SEGMENTATION_DISABLE, MAC_LONG, ZERO_CYCLE_BRANCH, BIT_IS_GENERAL, REG_IS_GENERAL};
    n_req += int'(v);
  endtask : step

  // Print the counts and the verdict, then stop
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    void'($urandom(24490));
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b0;
    step(1'b0, 8'h00, 8'h00);
    // Reset in mid-run while a division is pending
    step(1'b1, 8'h5b, 8'h00);
    @(posedge CLK_SYS);
    OPC_VALID <= 1'b0;
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    #1;
    chk("reset", 16'h0000, 16'({DEC_VALID, DEC_OP, DEC_LENGTH, DEC_CYCLES, RESULT_PENDING}));
    p_v = 1'b0;
    pend = 0;
    n_req = 0;
    // Every opcode of the quarter, back to back
    for (int i = 0; i < 64; i++)
      step(1'b1, 8'(i), 8'($urandom));
    foreach (corner[k])
      step(1'b1, corner[k], 8'($urandom));
    step(1'b1, 8'hcc, 8'he0);
    // Division restarted while its wait runs
    step(1'b1, 8'h4b, 8'h00);
    repeat (9) step(1'b0, 8'h00, 8'h00);
    step(1'b1, 8'h7b, 8'h00);
    repeat (21) step(1'b0, 8'h00, 8'h00);
    repeat (400) step(1'($urandom), {2'h0, 6'($urandom)}, 8'($urandom));
    repeat (2) step(1'b0, 8'h00, 8'h00);
    chk("taken", 16'(n_req), 16'(taken));
    close_out();
  end
endmodule : opcode_decode_first_quarter_tb
